/* File: logic/afe_tuning_and_transparent_ctrl.sv */
// Modulation level source, antenna tuning and transparent mode control
// Assumes an Avalon-MM master on clk_sys, measurement unit on clk_sys,
// serial pins and demodulator outputs asynchronous to clk_sys
`timescale 1ns/1ps
`include "afe_params.svh"
module afe_tuning_and_transparent_ctrl
  import afe_pkg::*;
#(
  parameter int LEVEL_W = 8,
  parameter int TRIM_W  = 4
) (
  input  wire logic                clk_sys,
  input  wire logic                sys_rst,
  input  wire logic [7:0]          avs_address,
  input  wire logic                avs_read,
  input  wire logic                avs_write,
  input  wire logic [31:0]         avs_writedata,
  input  wire logic [3:0]          avs_byteenable,
  output logic      [31:0]         avs_readdata,
  output logic                     avs_waitrequest,
  output logic                     measReq,
  output measKind_t                measKind,
  input  wire logic                measDone,
  input  wire logic [7:0]          measValue,
  output logic                     txForceOn,
  output logic      [LEVEL_W-1:0]  driveLevel,
  output logic      [2*TRIM_W-1:0] tuningSwitchPins,
  input  wire logic                spiSsN,
  input  wire logic                spiSclk,
  input  wire logic                spiMosi,
  input  wire logic                amDemod,
  input  wire logic                pmDemod,
  input  wire logic                frameModulate,
  input  wire logic                frameRxOn,
  input  wire logic                frameMisoOut,
  input  wire logic                frameMisoOe,
  input  wire logic                frameIrq,
  output logic                     modulatorOn,
  output logic                     rxOn,
  output logic                     spiMisoOut,
  output logic                     spiMisoOe,
  output logic                     irqPinOut,
  output logic      [3:0]          framingCfg,
  output logic      [3:0]          analogCfg
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  generate
    if (LEVEL_W != 8 || TRIM_W != 4) begin : g_badParams
      $error("LEVEL_W must be 8 and TRIM_W must be 4");
    end
  endgenerate

  function automatic logic hit(input logic [7:0] addr,
                               input logic [5:0] off);
    hit = (addr[7:2] == off) && (addr[1:0] == 2'b00);
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0]   modCtrl_ff;
  logic [7:0]   modLevel_ff;
  logic [7:0]   normLevel_ff;
  logic [7:0]   modCalRes_ff;
  logic [7:0]   rxCfg_ff;
  logic [7:0]   antTarget_ff;
  logic [7:0]   antCtrl_ff;
  logic [7:0]   refAmp_ff;
  logic         antErr_ff;
  logic         resp_ff;
  logic         waitMeas_ff;
  logic         armed_ff;
  logic         transp_ff;
  logic         ssPrev_ff;
  calState_t    state_ff;
  calState_t    nxt_state;
  logic [4:0]   pinSync;
  logic         ssHigh;
  logic         sclkS;
  logic         mosiS;
  logic         amS;
  logic         pmS;
  logic         req;
  logic         accept;
  logic         cmdWr;
  logic         modStart;
  logic         antStart;
  logic         measStep;
  logic         modKeep;
  logic         antKeep;
  logic [15:0]  lhsAmp;
  logic [15:0]  rhsAmp;
  logic [7:0]   phaseDiff;
  logic [7:0]   modTrial;
  logic [7:0]   modRes;
  logic         modBusy;
  logic         modDone;
  logic [3:0]   antTrial;
  logic [3:0]   antRes;
  logic         antBusy;
  logic         antDone;
  logic [7:0]   modLevelSel;
  logic         nxt_mod;
  logic [3:0]   trimSel;
  logic         amEn;
  logic         pmEn;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  bit_sync #(.W(5)) u_pinSync (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .asyncIn ({spiSsN, spiSclk, spiMosi, amDemod, pmDemod}),
    .syncOut (pinSync)
  );

  assign ssHigh = pinSync[4];
  assign sclkS  = pinSync[3];
  assign mosiS  = pinSync[2];
  assign amS    = pinSync[1];
  assign pmS    = pinSync[0];

  // ----------------------------------------------------------------
  // Avalon-MM slave
  // ----------------------------------------------------------------
  assign req             = avs_read | avs_write;
  assign accept          = req & resp_ff;
  assign avs_waitrequest = req & ~resp_ff;
  assign cmdWr = accept & avs_write & avs_byteenable[0]
               & hit(avs_address, `OFF_COMMAND);

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      resp_ff      <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else begin
      resp_ff <= req & ~resp_ff;
      if (avs_read && !resp_ff) begin
        avs_readdata <= 32'h0000_0000;
        if (hit(avs_address, `OFF_MOD_CTRL))
          avs_readdata[7:0] <= modCtrl_ff;
        if (hit(avs_address, `OFF_MOD_LEVEL))
          avs_readdata[7:0] <= modLevel_ff;
        if (hit(avs_address, `OFF_NORM_LEVEL))
          avs_readdata[7:0] <= normLevel_ff;
        if (hit(avs_address, `OFF_MOD_DISP))
          avs_readdata[7:0] <= modCalRes_ff;
        if (hit(avs_address, `OFF_RX_CFG))
          avs_readdata[7:0] <= rxCfg_ff;
        if (hit(avs_address, `OFF_ANT_TARGET))
          avs_readdata[7:0] <= antTarget_ff;
        if (hit(avs_address, `OFF_ANT_DISP))
          avs_readdata[7:0] <= {antRes, antErr_ff, 3'b000};
        if (hit(avs_address, `OFF_ANT_CTRL))
          avs_readdata[7:0] <= antCtrl_ff;
        if (hit(avs_address, `OFF_STATUS))
          avs_readdata[7:0] <= {5'b00000, transp_ff, armed_ff,
                                ~state_ff[0]};
      end
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      modCtrl_ff   <= `MOD_CTRL_RST;
      modLevel_ff  <= `LEVEL_RST;
      normLevel_ff <= `LEVEL_RST;
      rxCfg_ff     <= `RX_CFG_RST;
      antTarget_ff <= `ANT_TARGET_RST;
      antCtrl_ff   <= `ANT_CTRL_RST;
    end else if (accept && avs_write && avs_byteenable[0]) begin
      if (hit(avs_address, `OFF_MOD_CTRL))
        modCtrl_ff <= avs_writedata[7:0];
      if (hit(avs_address, `OFF_MOD_LEVEL))
        modLevel_ff <= avs_writedata[7:0];
      if (hit(avs_address, `OFF_NORM_LEVEL))
        normLevel_ff <= avs_writedata[7:0];
      if (hit(avs_address, `OFF_RX_CFG))
        rxCfg_ff <= avs_writedata[7:0];
      if (hit(avs_address, `OFF_ANT_TARGET))
        antTarget_ff <= avs_writedata[7:0];
      if (hit(avs_address, `OFF_ANT_CTRL))
        antCtrl_ff <= avs_writedata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Calibration sequencer
  // ----------------------------------------------------------------
  // own depth calibration
  assign modStart = cmdWr && state_ff == ST_IDLE
                  && avs_writedata[`CMD_MODCAL_BIT]
                  && !modCtrl_ff[`MOD_SRC_BIT];
  assign antStart = cmdWr && state_ff == ST_IDLE
                  && avs_writedata[`CMD_ANTCAL_BIT]
                  && !avs_writedata[`CMD_MODCAL_BIT];
  assign measStep = waitMeas_ff & measDone;

  // Keep extra resistance while amplitude stays at or above target
  assign lhsAmp  = 16'(measValue) * 16'({1'b1, modCtrl_ff[6:1]});
  assign rhsAmp  = {2'b00, refAmp_ff, 6'b000000};
  assign modKeep = lhsAmp >= rhsAmp;
  assign antKeep = measValue > antTarget_ff;
  assign phaseDiff = (measValue >= antTarget_ff)
                   ? measValue - antTarget_ff
                   : antTarget_ff - measValue;

  sar_search #(.W(LEVEL_W)) u_modSar (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .start   (state_ff == ST_MREF && measStep),
    .step    (state_ff == ST_MSAR && measStep),
    .keep    (modKeep),
    .trial   (modTrial),
    .result  (modRes),
    .busy    (modBusy),
    .done    (modDone)
  );

  sar_search #(.W(TRIM_W)) u_antSar (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .start   (antStart),
    .step    (state_ff == ST_ASAR && measStep),
    .keep    (antKeep),
    .trial   (antTrial),
    .result  (antRes),
    .busy    (antBusy),
    .done    (antDone)
  );

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (modStart) nxt_state = ST_MREF;
        else if (antStart) nxt_state = ST_ASAR;
      end
      ST_MREF: if (measStep) nxt_state = ST_MSAR;
      ST_MSAR: if (modDone) nxt_state = ST_IDLE;
      ST_ASAR: if (antDone) nxt_state = ST_AFIN;
      ST_AFIN: if (measStep) nxt_state = ST_IDLE;
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) state_ff <= ST_IDLE;
    else         state_ff <= nxt_state;
  end

  // One measurement per trial, issued once the drive has settled
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      waitMeas_ff <= 1'b0;
      measReq     <= 1'b0;
    end else begin
      measReq <= 1'b0;
      if (measStep) begin
        waitMeas_ff <= 1'b0;
      end else if (!waitMeas_ff && !measReq && !modDone && !antDone
                   && (state_ff == ST_MREF
                       || (state_ff == ST_MSAR && modBusy)
                       || (state_ff == ST_ASAR && antBusy)
                       || state_ff == ST_AFIN)) begin
        waitMeas_ff <= 1'b1;
        measReq     <= 1'b1;
      end
    end
  end

  assign measKind  = (state_ff == ST_ASAR || state_ff == ST_AFIN)
                   ? MEAS_PHASE : MEAS_AMP;
  assign txForceOn = ~state_ff[0];

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      refAmp_ff    <= 8'h00;
      modCalRes_ff <= 8'h00;
      antErr_ff    <= 1'b0;
    end else begin
      if (state_ff == ST_MREF && measStep) refAmp_ff <= measValue;
      if (modDone) modCalRes_ff <= modRes;
      if (state_ff == ST_AFIN && measStep)
        antErr_ff <= phaseDiff > `ANT_PHASE_TOL;
    end
  end

  // ----------------------------------------------------------------
  // Drive level and tuning switches
  // ----------------------------------------------------------------
  // host or calibrated level source
  assign modLevelSel = modCtrl_ff[`MOD_SRC_BIT] ? modLevel_ff
                                                : modCalRes_ff;
  assign trimSel = (state_ff == ST_ASAR) ? antTrial
                 : antCtrl_ff[`ANT_MAN_BIT] ? antCtrl_ff[3:0]
                 : antRes;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      driveLevel       <= `LEVEL_RST;
      tuningSwitchPins <= '0;
    end else begin
      if (state_ff == ST_MSAR) driveLevel <= modTrial;
      else if (nxt_mod && state_ff == ST_IDLE) driveLevel <= modLevelSel;
      else driveLevel <= normLevel_ff;
      tuningSwitchPins <= {trimSel, trimSel};
    end
  end

  // ----------------------------------------------------------------
  // Transparent mode
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      armed_ff  <= 1'b0;
      transp_ff <= 1'b0;
      ssPrev_ff <= 1'b1;
    end else begin
      ssPrev_ff <= ssHigh;
      if (accept) begin
        transp_ff <= 1'b0;
        armed_ff  <= cmdWr & avs_writedata[`CMD_TRANSP_BIT];
      end else if (armed_ff && ssHigh && !ssPrev_ff) begin
        transp_ff <= 1'b1;
        armed_ff  <= 1'b0;
      end else if (!ssHigh) begin
        transp_ff <= 1'b0;
      end
    end
  end

  assign amEn    = rxCfg_ff[`CFG_AM_BIT];
  assign pmEn    = rxCfg_ff[`CFG_PM_BIT];
  assign nxt_mod = transp_ff ? mosiS : frameModulate;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      modulatorOn <= 1'b0;
      rxOn        <= 1'b0;
      spiMisoOut  <= 1'b0;
      spiMisoOe   <= 1'b0;
      irqPinOut   <= 1'b0;
    end else if (transp_ff) begin
      modulatorOn <= nxt_mod;
      rxOn        <= sclkS;
      spiMisoOe   <= 1'b1;
      spiMisoOut  <= amEn ? amS : pmS;
      irqPinOut   <= amEn & pmEn & pmS;
    end else begin
      modulatorOn <= nxt_mod;
      rxOn        <= frameRxOn;
      spiMisoOut  <= frameMisoOut;
      spiMisoOe   <= frameMisoOe;
      irqPinOut   <= frameIrq;
    end
  end

  assign framingCfg = transp_ff ? 4'h0 : rxCfg_ff[7:4];
  assign analogCfg  = rxCfg_ff[3:0];

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  property p_hostLevel;
    (state_ff == ST_IDLE && nxt_mod && modCtrl_ff[`MOD_SRC_BIT])
      |=> driveLevel == $past(modLevel_ff);
  endproperty
  a_hostLevel: assert property (p_hostLevel)
    else $error("host level not applied");

  property p_calLevel;
    (state_ff == ST_IDLE && nxt_mod && !modCtrl_ff[`MOD_SRC_BIT])
      |=> driveLevel == $past(modCalRes_ff);
  endproperty
  a_calLevel: assert property (p_calLevel)
    else $error("calibrated level not applied");

  property p_pairs;
    tuningSwitchPins[7:4] == tuningSwitchPins[3:0];
  endproperty
  a_pairs: assert property (p_pairs)
    else $error("switch pair mismatch");

  property p_antPhase;
    (measReq && antBusy) |-> measKind == MEAS_PHASE;
  endproperty
  a_antPhase: assert property (p_antPhase)
    else $error("antenna search without phase measure");

  property p_antKeep;
    (state_ff == ST_ASAR && measStep && antTrial == 4'h8)
      |=> antRes[3] == $past(measValue > antTarget_ff);
  endproperty
  a_antKeep: assert property (p_antKeep)
    else $error("phase compare wrong");

  property p_antErr;
    (state_ff == ST_AFIN && measStep)
      |=> antErr_ff == ($past(phaseDiff) > `ANT_PHASE_TOL)
          && state_ff == ST_IDLE;
  endproperty
  a_antErr: assert property (p_antErr)
    else $error("error flag wrong");

  property p_manual;
    (state_ff != ST_ASAR && antCtrl_ff[`ANT_MAN_BIT])
      |=> tuningSwitchPins[3:0] == $past(antCtrl_ff[3:0]);
  endproperty
  a_manual: assert property (p_manual)
    else $error("manual trim not applied");

  property p_enter;
    (armed_ff && !accept && ssHigh && !ssPrev_ff) |=> transp_ff;
  endproperty
  a_enter: assert property (p_enter)
    else $error("transparent not entered");

  property p_stayHigh;
    !ssHigh |=> !transp_ff;
  endproperty
  a_stayHigh: assert property (p_stayHigh)
    else $error("transparent with select low");

  property p_mosi;
    transp_ff |=> modulatorOn == $past(mosiS);
  endproperty
  a_mosi: assert property (p_mosi)
    else $error("modulator not following MOSI");

  property p_sclk;
    transp_ff |=> rxOn == $past(sclkS);
  endproperty
  a_sclk: assert property (p_sclk)
    else $error("receiver not following SCLK");

  property p_misoAm;
    (transp_ff && amEn) |=> spiMisoOut == $past(amS) && spiMisoOe;
  endproperty
  a_misoAm: assert property (p_misoAm)
    else $error("amplitude channel not on MISO");

  property p_irqPm;
    (transp_ff && amEn && pmEn) |=> irqPinOut == $past(pmS);
  endproperty
  a_irqPm: assert property (p_irqPm)
    else $error("phase channel not on interrupt");

  property p_single;
    (transp_ff && !(amEn && pmEn)) |=> !irqPinOut;
  endproperty
  a_single: assert property (p_single)
    else $error("interrupt not low on single channel");

  property p_framing;
    transp_ff |-> framingCfg == 4'h0;
  endproperty
  a_framing: assert property (p_framing)
    else $error("framing bits active in transparent");

  property p_busEnds;
    accept |=> !transp_ff;
  endproperty
  a_busEnds: assert property (p_busEnds)
    else $error("bus access left transparent on");

endmodule

/* File: logic/afe_params.svh */
// Offsets, field positions, reset values and limits of the AFE control block
// Assumes a byte-addressed Avalon-MM slave, one 8-bit register per word
`ifndef AFE_PARAMS_SVH
`define AFE_PARAMS_SVH

// ----------------------------------------------------------------
// Register word offsets
// ----------------------------------------------------------------
`define OFF_MOD_CTRL   6'h00
`define OFF_MOD_LEVEL  6'h01
`define OFF_NORM_LEVEL 6'h02
`define OFF_MOD_DISP   6'h03
`define OFF_COMMAND    6'h04
`define OFF_RX_CFG     6'h05
`define OFF_ANT_TARGET 6'h06
`define OFF_ANT_DISP   6'h07
`define OFF_ANT_CTRL   6'h08
`define OFF_STATUS     6'h09

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define MOD_SRC_BIT    7
`define MOD_DEPTH_LSB  1
`define ANT_MAN_BIT    7
`define CMD_MODCAL_BIT 0
`define CMD_ANTCAL_BIT 1
`define CMD_TRANSP_BIT 2
`define CFG_AM_BIT     0
`define CFG_PM_BIT     1
`define ANTD_ERR_BIT   3

// ----------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------
`define MOD_CTRL_RST   8'h00
`define LEVEL_RST      8'h00
`define RX_CFG_RST     8'h03
`define ANT_TARGET_RST 8'h80
`define ANT_CTRL_RST   8'h00
`define ANT_PHASE_TOL  8'h04

`endif

/* File: logic/afe_pkg.sv */
// Types shared by the AFE control block
// Assumes the params header is included by users that need constants
package afe_pkg;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_MREF = 5'h02,
    ST_MSAR = 5'h04,
    ST_ASAR = 5'h08,
    ST_AFIN = 5'h10
  } calState_t;

  typedef enum logic {
    MEAS_AMP   = 1'b0,
    MEAS_PHASE = 1'b1
  } measKind_t;

endpackage

/* File: logic/bit_sync.sv */
// Two-flop synchroniser for a group of independent levels
// Assumes each bit is a slow level from outside the clk_sys domain
`timescale 1ns/1ps
module bit_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] syncOut
);

  logic [W-1:0] meta_ff;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      meta_ff <= '0;
      syncOut <= '0;
    end else begin
      meta_ff <= asyncIn;
      syncOut <= meta_ff;
    end
  end

endmodule

/* File: logic/sar_search.sv */
// Successive approximation over a W-bit code, MSB first
// Assumes step pulses only once the trial code has been measured
`timescale 1ns/1ps
module sar_search #(
  parameter int W = 4
) (
  input  wire logic         clk_sys,
  input  wire logic         sys_rst,
  input  wire logic         start,
  input  wire logic         step,
  input  wire logic         keep,
  output logic      [W-1:0] trial,
  output logic      [W-1:0] result,
  output logic              busy,
  output logic              done
);

  logic [W-1:0] bit_ff;

  generate
    if (W < 1 || W > 16) begin : g_badW
      $error("sar_search width out of range");
    end
  endgenerate

  assign trial = result | bit_ff;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      result <= '0;
      bit_ff <= '0;
      busy   <= 1'b0;
      done   <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        result <= '0;
        bit_ff <= {1'b1, {(W-1){1'b0}}};
        busy   <= 1'b1;
      end else if (busy && step) begin
        if (keep) begin
          result <= result | bit_ff;
        end
        bit_ff <= bit_ff >> 1;
        if (bit_ff[0]) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end

endmodule

/* File: verif/meas_model.sv */
// Measurement unit model answering the block's measurement requests
// Assumes measReq pulses for one clk_sys cycle, one request outstanding
`timescale 1ns/1ps
module meas_model
  import afe_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       measReq,
  input  wire measKind_t  measKind,
  input  wire logic [7:0] driveLevel,
  input  wire logic [7:0] tuningSwitchPins,
  output logic            measDone,
  output logic      [7:0] measValue
);
  int unsigned wt;
  initial begin
    measDone  = 1'b0;
    measValue = 8'h00;
    forever begin
      @(posedge clk_sys);
      if (measReq === 1'b1) begin
        wt = 1 + $urandom_range(3);
        repeat (wt) @(posedge clk_sys);
        measValue <= (measKind == MEAS_PHASE) ?
          {tuningSwitchPins[3:0], 4'h8} : 8'hFF - driveLevel;
        measDone  <= 1'b1;
        @(posedge clk_sys);
        measDone  <= 1'b0;
        measValue <= ~measValue;
      end
    end
  end
endmodule

/* File: verif/tb.sv */
// Self-checking bench for the AFE tuning and transparent control
// Assumes the measurement model on the far side of the block
`timescale 1ns/1ps
`include "afe_params.svh"
module tb;
  import afe_pkg::*;
  logic clk_sys=0, sys_rst=1, rd=0, wr=0, md, ssN=0, sclk=0, mosi=0;
  logic am=0, pm=0, fMod=0;
  logic [7:0] adr=0, q, t, r, pins, lvl, e;
  logic [31:0] wd=0, rdat;
  logic wreq, mReq, mOn, rxOn, miso, misoOe, irq, txOn;
  measKind_t kind;
  logic [3:0] frm, acfg;
  int failures=0, check_count=0;
  afe_tuning_and_transparent_ctrl dut(.clk_sys(clk_sys),
    .sys_rst(sys_rst), .avs_address(adr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wd), .avs_byteenable(4'hF),
    .avs_readdata(rdat), .avs_waitrequest(wreq), .measReq(mReq),
    .measKind(kind), .measDone(md), .measValue(q),
    .txForceOn(txOn), .driveLevel(lvl), .tuningSwitchPins(pins),
    .spiSsN(ssN), .spiSclk(sclk), .spiMosi(mosi), .amDemod(am),
    .pmDemod(pm), .frameModulate(fMod), .frameRxOn(1'b0),
    .frameMisoOut(1'b0), .frameMisoOe(1'b0), .frameIrq(1'b0),
    .modulatorOn(mOn), .rxOn(rxOn), .spiMisoOut(miso),
    .spiMisoOe(misoOe), .irqPinOut(irq), .framingCfg(frm),
    .analogCfg(acfg));
  meas_model mm(.clk_sys(clk_sys), .measReq(mReq), .measKind(kind),
    .driveLevel(lvl), .tuningSwitchPins(pins), .measDone(md),
    .measValue(q));
  initial forever #2 clk_sys = ~clk_sys;
  task automatic bus(input logic w, input logic [5:0] o,
                     input logic [7:0] d, output logic [7:0] v);
    adr <= {o, 2'b00};
    wd <= {24'h0, d};
    wr <= w;
    rd <= !w;
    do @(posedge clk_sys); while (wreq !== 1'b0);
    v = rdat[7:0];
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic chk(input string nm, input logic [7:0] e, s);
    check_count++;
    if (s !== e) begin
      $display("BAD %s exp %h got %h", nm, e, s);
      failures++;
    end
  endtask
  task automatic complete_run;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  function automatic logic [7:0] antExp(input logic [7:0] tg);
    logic [3:0] c, k;
    logic [7:0] p;
    c = 0;
    for (int b = 3; b >= 0; b--) begin
      k = c | (4'h1 << b);
      if ({k, 4'h8} > tg) c = k;
    end
    p = {c, 4'h8};
    return {c, ((p > tg ? p - tg : tg - p) > 8'h04), 3'b000};
  endfunction
  function automatic logic [7:0] modExp(input logic [5:0] d);
    logic [7:0] c, k;
    c = 0;
    for (int b = 7; b >= 0; b--) begin
      k = c | (8'h01 << b);
      if (16'(8'hFF - k) * (16'h0040 + d) >= 16'h3FC0) c = k;
    end
    return c;
  endfunction
  initial begin
    repeat (20000) @(posedge clk_sys);
    failures++;
    complete_run();
  end
  initial begin
    void'($urandom(96964));
    repeat (8) @(posedge clk_sys);
    sys_rst <= 0;
    repeat (3) @(posedge clk_sys);
    bus(0, `OFF_RX_CFG, 0, r); chk("rxcfg", `RX_CFG_RST, r);
    bus(0, `OFF_ANT_TARGET, 0, r); chk("tgt", `ANT_TARGET_RST, r);
    bus(0, 6'h3F, 0, r); chk("unmapped", 8'h00, r);
    $display("reset test done");
    for (int i = 0; i < 6; i++) begin
      t = (i == 0) ? 8'h80 : $urandom;
      bus(1, `OFF_ANT_CTRL, 8'h80 | t[3:0], r);
      repeat (2) @(posedge clk_sys);
      chk("manual", {t[3:0], t[3:0]}, pins);
      bus(1, `OFF_ANT_CTRL, 8'h00, r);
      bus(1, `OFF_ANT_TARGET, t, r);
      bus(1, `OFF_COMMAND, 8'h02, r);
      chk("txon", 8'h01, {7'h0, txOn});
      do bus(0, `OFF_STATUS, 0, r); while (r[0] !== 1'b0);
      chk("txoff", 8'h00, {7'h0, txOn});
      bus(0, `OFF_ANT_DISP, 0, r);
      e = antExp(t);
      chk("antdisp", e, r);
      chk("autopins", {e[7:4], e[7:4]}, pins);
    end
    $display("antenna test done");
    t = $urandom;
    bus(1, `OFF_MOD_CTRL, 8'h80, r);
    bus(1, `OFF_MOD_LEVEL, t, r);
    bus(1, `OFF_NORM_LEVEL, ~t, r);
    fMod <= 1;
    repeat (3) @(posedge clk_sys);
    chk("modlvl", t, lvl);
    fMod <= 0;
    repeat (3) @(posedge clk_sys);
    chk("normlvl", ~t, lvl);
    bus(1, `OFF_NORM_LEVEL, 8'h00, r);
    for (int i = 0; i < 4; i++) begin
      t = {1'b0, 6'($urandom), 1'b0};
      bus(1, `OFF_MOD_CTRL, t, r);
      bus(1, `OFF_COMMAND, 8'h01, r);
      do bus(0, `OFF_STATUS, 0, r); while (r[0] !== 1'b0);
      bus(0, `OFF_MOD_DISP, 0, r);
      e = modExp(t[6:1]);
      chk("moddisp", e, r);
      fMod <= 1;
      repeat (3) @(posedge clk_sys);
      chk("callvl", e, lvl);
      fMod <= 0;
    end
    $display("level test done");
    for (int i = 0; i < 9; i++) begin
      t = {4'($urandom), 2'b00, 2'(i % 3 + 1)};
      bus(1, `OFF_RX_CFG, t, r);
      ssN <= 0;
      bus(1, `OFF_COMMAND, 8'h04, r);
      ssN <= 1;
      repeat (8) @(posedge clk_sys);
      {mosi, sclk, am, pm} <= 4'($urandom);
      repeat (8) @(posedge clk_sys);
      chk("frm", 8'h0, {4'h0, frm});
      chk("mod", {7'h0, mosi}, {7'h0, mOn});
      chk("rx", {7'h0, sclk}, {7'h0, rxOn});
      chk("miso", {7'h0, t[0] ? am : pm}, {7'h0, miso});
      chk("irq", {7'h0, &t[1:0] & pm}, {7'h0, irq});
      chk("oe", 8'h01, {7'h0, misoOe});
      chk("acfg", {4'h0, t[3:0]}, {4'h0, acfg});
      if (i % 2) begin
        ssN <= 0;
        repeat (4) @(posedge clk_sys);
      end
      bus(0, `OFF_STATUS, 0, r);
      chk("tstat", (i % 2) ? 8'h00 : 8'h04, r);
      repeat (3) @(posedge clk_sys);
      chk("exit", {7'h0, fMod}, {7'h0, mOn});
      bus(0, `OFF_STATUS, 0, r);
      chk("left", 8'h00, r);
    end
    $display("transparent test done");
    complete_run();
  end
endmodule
